/* logic/smef_defines.svh */
// Constants for the serial message end framer: register indices,
// select bit positions, reset values and timing counts.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SMEF_DEFINES_SVH
`define SMEF_DEFINES_SVH

// Register word indices on the plain register port
`define SMEF_A_CTRL 5'h00
`define SMEF_A_START 5'h01
`define SMEF_A_END 5'h02
`define SMEF_A_QUIET 5'h03
`define SMEF_A_MATCH 5'h04
`define SMEF_A_BAUD 5'h05
`define SMEF_A_WAIT 5'h06
`define SMEF_A_MSGT 5'h07
`define SMEF_A_GAP 5'h08
`define SMEF_A_MAXLEN 5'h09
`define SMEF_A_LENPOS 5'h0a
`define SMEF_A_LENSZ 5'h0b
`define SMEF_A_LENM 5'h0c
`define SMEF_A_SEQ 5'h10

// Control bits
`define SMEF_CTRL_GO 0
`define SMEF_CTRL_ABORT 1

// End select bit positions
`define SMEF_END_RESP 0
`define SMEF_END_MSGT 1
`define SMEF_END_GAP 2
`define SMEF_END_MAX 3
`define SMEF_END_LEN 4
`define SMEF_END_SEQ 5

// Start select bit positions; sequences occupy 4 to 7
`define SMEF_ST_CHAR 0
`define SMEF_ST_ANY 1
`define SMEF_ST_BRK 2
`define SMEF_ST_IDLE 3
`define SMEF_ST_SEQ 4

// Reset values
`define SMEF_BAUD_RST 16'h0364
`define SMEF_LENSZ_RST 3'h1

// Timing: one millisecond tick at the system clock rate
`define SMEF_MS_NS 1000000
`define SMEF_CLK_NS 10
`define SMEF_MS_CYCLES (`SMEF_MS_NS / `SMEF_CLK_NS)

`endif

/* logic/smef_pkg.sv */
// Types shared by the serial message end framer.
// Assumes nothing of its surroundings.
package smef_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_MSG} smef_state_t;
    typedef logic [31:0] smef_word_t;
    typedef logic [4:0] smef_addr_t;
    typedef logic [7:0] smef_byte_t;
endpackage : smef_pkg

/* logic/smef_end_framer.sv */
// Receive framing for a serial message port: start and end conditions.
// Assumes a character receiver that pulses rxValid once per good character
// at its last stop bit, and a register master on the same clock.
//
// The register offsets and strobed register access are this design's own decisions.
`include "smef_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module smef_end_framer #(
    parameter int MS_CYCLES = `SMEF_MS_CYCLES // Clock cycles per millisecond
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire smef_pkg::smef_addr_t regAddr,
    input wire smef_pkg::smef_word_t regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output var smef_pkg::smef_word_t regRdata,
    input wire logic rxValid,
    input wire smef_pkg::smef_byte_t rxData,
    input wire logic rxBreak,
    input wire logic rxLineIdle,
    input wire logic txDone,
    output var logic msgValid,
    output var smef_pkg::smef_byte_t msgData,
    output var logic msgDone,
    output var logic msgError,
    output var logic opBusy
);
    import smef_pkg::*;

    // Highest compared position of a mask
    function automatic logic [2:0] lastSet(input logic [4:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 5; i++) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : lastSet

    // Lowest compared position of a mask
    function automatic logic [2:0] firstSet(input logic [4:0] m);
        logic [2:0] r;
        r = 3'h4;
        for (int i = 4; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : firstSet

    // Sequence compare; newest char aligns with position top
    function automatic logic seqHit(input logic [39:0] h, input logic [39:0] c,
                                    input logic [4:0] m, input logic [2:0] top);
        logic ok;
        ok = (m != 5'h00);
        for (int i = 0; i < 5; i++) begin
            if (m[i]) begin // Clear bits are wildcards
                if (3'(i) > top) begin
                    ok = 1'b0;
                end else if (h[8*(int'(top)-i) +: 8] != c[8*i +: 8]) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction : seqHit

    // Configuration registers
    logic [7:0] startSel_ff; // Start condition enables, any combination
    logic [5:0] endSel_ff; // End condition enables, any combination
    logic [15:0] quietLim_ff; // Idle bit times for idle start
    logic [7:0] matchByte_ff; // Opening match byte
    logic [15:0] baudDiv_ff; // Clock cycles per bit
    logic [15:0] waitLim_ff; // First char wait, ms
    logic [15:0] msgLim_ff; // Whole message limit, ms
    logic [15:0] gapLim_ff; // Gap limit, bit times
    logic [15:0] maxLen_ff; // Maximum characters
    logic [15:0] lenPos_ff; // Length field position, 1-based
    logic [2:0] lenSize_ff; // Length field bytes
    logic [15:0] lenM_ff; // Trailing characters
    logic [39:0] seqChars_ff [5]; // Sequences 0..3 start, 4 end
    logic [4:0] seqMask_ff [5]; // Compare masks

    // Operation state
    smef_state_t state_ff;
    logic [31:0] msCnt_ff; // Millisecond prescaler
    logic [15:0] bitCnt_ff; // Bit time prescaler
    logic [15:0] waitMs_ff; // Response wait elapsed
    logic gotChar_ff; // A char arrived during the wait
    logic [15:0] quietCnt_ff; // Quiet line bit times
    logic [15:0] msgMs_ff; // Message time elapsed
    logic [15:0] gapBits_ff; // Bit times since last char
    logic [15:0] msgCnt_ff; // Characters in message
    logic [31:0] lenVal_ff; // Assembled length field
    logic [31:0] hist_ff; // Four previous characters
    logic [5:0] cause_ff; // End causes of last message
    logic done_ff; // Last operation ended cleanly
    logic err_ff; // Last operation ended in error
    logic msgValid_ff;
    logic [7:0] msgData_ff;
    logic msgDone_ff;
    logic msgError_ff;
    logic [31:0] rdata_ff;

    // Decoded strobes and events
    logic idle;
    logic goReq;
    logic abortReq;
    logic msTick;
    logic bitTick;
    logic [39:0] newHist;
    logic [15:0] newCnt;
    logic sChar;
    logic sAny;
    logic sBrk;
    logic sIdle;
    logic seqStart;
    logic startNow;
    logic chr;
    logic respFire;
    logic [15:0] fieldEnd;
    logic inField;
    logic [31:0] lenNext;
    logic [31:0] target;
    logic endMsg;
    logic endGap;
    logic endMax;
    logic endLen;
    logic endSeq;
    logic [5:0] cause;
    logic endNow;

    assign idle = (state_ff == ST_IDLE);
    assign goReq = regWrite && regAddr == `SMEF_A_CTRL && regWdata[`SMEF_CTRL_GO];
    assign abortReq = regWrite && regAddr == `SMEF_A_CTRL && regWdata[`SMEF_CTRL_ABORT];

    // Config writes only land while idle, so an operation sees a fixed set
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            startSel_ff <= 8'h00;
            endSel_ff <= 6'h00;
            quietLim_ff <= 16'h0000;
            matchByte_ff <= 8'h00;
            baudDiv_ff <= `SMEF_BAUD_RST;
            waitLim_ff <= 16'h0000;
            msgLim_ff <= 16'h0000;
            gapLim_ff <= 16'h0000;
            maxLen_ff <= 16'h0000;
            lenPos_ff <= 16'h0000;
            lenSize_ff <= `SMEF_LENSZ_RST;
            lenM_ff <= 16'h0000;
            for (int k = 0; k < 5; k++) begin
                seqChars_ff[k] <= 40'h00_0000_0000;
                seqMask_ff[k] <= 5'h00;
            end
        end else if (regWrite && idle) begin
            case (regAddr)
                `SMEF_A_START: startSel_ff <= regWdata[7:0];
                `SMEF_A_END: endSel_ff <= regWdata[5:0];
                `SMEF_A_QUIET: quietLim_ff <= regWdata[15:0];
                `SMEF_A_MATCH: matchByte_ff <= regWdata[7:0];
                `SMEF_A_BAUD: baudDiv_ff <= regWdata[15:0];
                `SMEF_A_WAIT: waitLim_ff <= regWdata[15:0];
                `SMEF_A_MSGT: msgLim_ff <= regWdata[15:0];
                `SMEF_A_GAP: gapLim_ff <= regWdata[15:0];
                `SMEF_A_MAXLEN: maxLen_ff <= regWdata[15:0];
                `SMEF_A_LENPOS: lenPos_ff <= regWdata[15:0];
                `SMEF_A_LENSZ: lenSize_ff <= regWdata[2:0];
                `SMEF_A_LENM: lenM_ff <= regWdata[15:0];
                default: ;
            endcase
            // Each sequence: chars 1-4 in one word, char 5 and mask in the next
            for (int k = 0; k < 5; k++) begin
                if (regAddr == 5'(`SMEF_A_SEQ + 2 * k)) begin
                    seqChars_ff[k][31:0] <= regWdata;
                end
                if (regAddr == 5'(`SMEF_A_SEQ + 2 * k + 1)) begin
                    seqChars_ff[k][39:32] <= regWdata[15:8];
                    seqMask_ff[k] <= regWdata[4:0];
                end
            end
        end
    end

    // Millisecond tick, realigned on go but not on txDone, so only a response wait timed from go is exact
    assign msTick = (msCnt_ff == 32'(MS_CYCLES - 1));
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            msCnt_ff <= 32'h0000_0000;
        end else if (goReq || msTick) begin
            msCnt_ff <= 32'h0000_0000;
        end else begin
            msCnt_ff <= msCnt_ff + 32'h1;
        end
    end

    // Bit time tick from the baud divisor; a zero divisor ticks every cycle
    assign bitTick = (17'(bitCnt_ff) + 17'h1 >= 17'(baudDiv_ff));
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bitCnt_ff <= 16'h0000;
        end else if (bitTick) begin
            bitCnt_ff <= 16'h0000;
        end else begin
            bitCnt_ff <= bitCnt_ff + 16'h1;
        end
    end

    // Start conditions; any one of them begins the message
    assign newHist = {hist_ff, rxData};
    assign sChar = startSel_ff[`SMEF_ST_CHAR] && rxValid && rxData == matchByte_ff;
    assign sAny = startSel_ff[`SMEF_ST_ANY] && rxValid;
    assign sBrk = startSel_ff[`SMEF_ST_BRK] && rxBreak;
    assign sIdle = startSel_ff[`SMEF_ST_IDLE] && quietCnt_ff >= quietLim_ff;
    always_comb begin
        seqStart = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (startSel_ff[`SMEF_ST_SEQ + k] && rxValid &&
                seqHit(newHist, seqChars_ff[k], seqMask_ff[k], lastSet(seqMask_ff[k]))) begin
                seqStart = 1'b1;
            end
        end
    end
    assign startNow = (state_ff == ST_WAIT) && (sChar || sAny || sBrk || sIdle || seqStart);

    // A char joins the message while in it, or when it starts it by match or any-char; a sequence start char does not
    assign chr = rxValid && (state_ff == ST_MSG || (state_ff == ST_WAIT && (sChar || sAny)));
    assign newCnt = msgCnt_ff + 16'h1;

    // Response wait only guards the first char; it closes no message
    assign respFire = (state_ff == ST_WAIT) && endSel_ff[`SMEF_END_RESP] && !gotChar_ff
                      && !rxValid && waitMs_ff >= waitLim_ff;

    // Length field: big-endian, sized 1, 2 or 4, at position N
    assign fieldEnd = lenPos_ff + {13'h0000, lenSize_ff} - 16'h1;
    assign inField = chr && newCnt >= lenPos_ff && newCnt <= fieldEnd;
    assign lenNext = inField ? {lenVal_ff[23:0], rxData} : lenVal_ff;
    assign target = {16'h0000, fieldEnd} + lenNext + {16'h0000, lenM_ff};

    // All enabled end conditions race; whichever is true first ends it
    assign endMsg = endSel_ff[`SMEF_END_MSGT] && state_ff == ST_MSG && msgMs_ff >= msgLim_ff;
    assign endGap = endSel_ff[`SMEF_END_GAP] && state_ff == ST_MSG && gapBits_ff > gapLim_ff;
    assign endMax = endSel_ff[`SMEF_END_MAX] && chr && newCnt == maxLen_ff;
    assign endLen = endSel_ff[`SMEF_END_LEN] && chr && newCnt >= fieldEnd
                    && {16'h0000, newCnt} == target;
    // End sequence spans all five positions: trailing wildcards must arrive
    // while leading ones below the lowest compared position need not arrive
    assign endSeq = endSel_ff[`SMEF_END_SEQ] && chr
                    && seqHit(newHist, seqChars_ff[4], seqMask_ff[4], 3'h4)
                    && newCnt >= {13'h0000, 3'h5 - firstSet(seqMask_ff[4])};
    assign cause = {endSeq, endLen, endMax, endGap, endMsg, 1'b0};
    assign endNow = (cause != 6'h00) && (state_ff == ST_MSG || startNow);

    // Operation sequencer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (goReq) begin
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (abortReq || respFire || endNow) begin
                        state_ff <= ST_IDLE;
                    end else if (startNow) begin
                        state_ff <= ST_MSG;
                    end
                end
                ST_MSG: begin
                    if (abortReq || endNow) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Response wait timer, restarted when our own transmission completes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            waitMs_ff <= 16'h0000;
            gotChar_ff <= 1'b0;
        end else if (goReq || txDone) begin
            waitMs_ff <= 16'h0000;
            gotChar_ff <= 1'b0;
        end else begin
            if (msTick && waitMs_ff != 16'hffff) begin
                waitMs_ff <= waitMs_ff + 16'h1;
            end
            if (rxValid) begin
                gotChar_ff <= 1'b1;
            end
        end
    end

    // Quiet line counter in bit times; any activity restarts it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            quietCnt_ff <= 16'h0000;
        end else if (!rxLineIdle || rxValid || state_ff != ST_WAIT) begin
            quietCnt_ff <= 16'h0000;
        end else if (bitTick && quietCnt_ff != 16'hffff) begin
            quietCnt_ff <= quietCnt_ff + 16'h1;
        end
    end

    // Message timer from the start condition
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            msgMs_ff <= 16'h0000;
        end else if (startNow) begin
            msgMs_ff <= 16'h0000;
        end else if (msTick && msgMs_ff != 16'hffff) begin
            msgMs_ff <= msgMs_ff + 16'h1;
        end
    end

    // Gap counter: cleared at each char's stop bit, counts bit times
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gapBits_ff <= 16'h0000;
        end else if (startNow || rxValid) begin
            gapBits_ff <= 16'h0000;
        end else if (bitTick && gapBits_ff != 16'hffff) begin
            gapBits_ff <= gapBits_ff + 16'h1;
        end
    end

    // Character count, length field and history
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            msgCnt_ff <= 16'h0000;
            lenVal_ff <= 32'h0000_0000;
            hist_ff <= 32'h0000_0000;
        end else begin
            if (goReq) begin
                msgCnt_ff <= 16'h0000;
                lenVal_ff <= 32'h0000_0000;
            end else if (chr) begin
                msgCnt_ff <= newCnt;
                lenVal_ff <= lenNext;
            end
            if (rxValid) begin
                hist_ff <= newHist[31:0];
            end
        end
    end

    // Delivery: every message char is passed on the cycle after it arrives, so a timeout loses none
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            msgValid_ff <= 1'b0;
            msgData_ff <= 8'h00;
        end else begin
            msgValid_ff <= chr;
            msgData_ff <= rxData;
        end
    end

    // Result pulses and sticky result; results clear only on a go while idle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            msgDone_ff <= 1'b0;
            msgError_ff <= 1'b0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            cause_ff <= 6'h00;
        end else begin
            msgDone_ff <= endNow && !endGap && !abortReq;
            msgError_ff <= !abortReq && ((endNow && endGap) || respFire);
            if (goReq && idle) begin
                done_ff <= 1'b0;
                err_ff <= 1'b0;
                cause_ff <= 6'h00;
            end else if (!abortReq && (endNow || respFire)) begin
                done_ff <= endNow && !endGap;
                err_ff <= endGap || respFire;
                cause_ff <= respFire ? 6'h01 : cause;
            end
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (!regRead) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            case (regAddr)
                `SMEF_A_CTRL: rdata_ff <= {msgCnt_ff, 2'h0, cause_ff, 5'h00, err_ff, done_ff, !idle};
                `SMEF_A_START: rdata_ff <= {24'h00_0000, startSel_ff};
                `SMEF_A_END: rdata_ff <= {26'h000_0000, endSel_ff};
                `SMEF_A_MATCH: rdata_ff <= {24'h00_0000, matchByte_ff};
                `SMEF_A_BAUD: rdata_ff <= {16'h0000, baudDiv_ff};
                `SMEF_A_MAXLEN: rdata_ff <= {16'h0000, maxLen_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign regRdata = rdata_ff;
    assign msgValid = msgValid_ff;
    assign msgData = msgData_ff;
    assign msgDone = msgDone_ff;
    assign msgError = msgError_ff;
    assign opBusy = !idle;

    maxlen_stop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (endMax && !endGap && !abortReq) |=> (msgDone_ff && state_ff == ST_IDLE))
        else $error("max length did not end the message");
    gap_error_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (endGap && !abortReq) |=> (msgError_ff && !msgDone_ff))
        else $error("gap overrun did not flag an error");
    resp_error_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == ST_WAIT && respFire && !abortReq) |=> (msgError_ff && idle && !msgValid_ff))
        else $error("response wait expiry not reported");
    idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        idle |=> !msgValid_ff)
        else $error("character delivered outside an operation");
    cfg_frozen_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !idle |=> ($stable(endSel_ff) && $stable(startSel_ff) && $stable(maxLen_ff)))
        else $error("configuration changed during an operation");
    msg_timer_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (endMsg && !endGap && !abortReq) |=> (msgDone_ff && cause_ff[1]))
        else $error("message timer did not end the message");
    char_pass_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == ST_MSG && rxValid) |=> (msgValid_ff && msgData_ff == $past(rxData)))
        else $error("received character not delivered");
    start_char_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == ST_WAIT && sChar && !respFire && !abortReq) |=> (msgValid_ff && msgCnt_ff == 16'h1))
        else $error("start character not taken as first");
    resp_nofinish_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == ST_MSG && endSel_ff == 6'h01 && !abortReq) |=> (state_ff == ST_MSG))
        else $error("response wait alone closed a message");
endmodule : smef_end_framer

`default_nettype wire

/* verification/smef_remote_dev.sv */
// Remote serial device model: hands whole characters to the framer's receive side.
// Assumes the framer's clock; one rxValid pulse for each character at its last stop bit.
`timescale 1ns/10ps
`default_nettype none
module smef_remote_dev (
    input wire logic sys_clk,
    output var logic rxValid,
    output var smef_pkg::smef_byte_t rxData,
    output var logic rxBreak,
    output var logic rxLineIdle
);
    import smef_pkg::*;
    // Line at rest: quiet, no break
    initial begin
        rxValid = 1'b0;
        rxData = 8'h5a;
        rxBreak = 1'b0;
        rxLineIdle = 1'b1;
    end
    // Characters sp+1 idle cycles apart; line busy from first to last
    task send_seq(input smef_byte_t s[$], input int sp);
        for (int i = 0; i < s.size(); i++) begin
            @(posedge sys_clk);
            rxValid <= 1'b1;
            rxData <= s[i];
            rxLineIdle <= 1'b0;
            @(posedge sys_clk);
            rxValid <= 1'b0;
            rxData <= ~s[i]; // Stale data inverted so it cannot pass as held
            repeat (sp) @(posedge sys_clk);
        end
        rxLineIdle <= 1'b1;
    endtask : send_seq
    // Line break for one cycle; it opens a frame without a character
    task send_break;
        @(posedge sys_clk);
        rxBreak <= 1'b1;
        @(posedge sys_clk);
        rxBreak <= 1'b0;
    endtask : send_break
endmodule : smef_remote_dev
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the message end framer: every end condition, the start conditions and abort.
// Assumes the remote device model and a short millisecond for the timers.
`include "smef_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    import smef_pkg::*;
    localparam int MS = 20; // Short millisecond keeps timer scenarios brief
    logic sys_clk, resetn, regWrite, regRead, txDone;
    logic rxValid, rxBreak, rxLineIdle, msgValid, msgDone, msgError, opBusy;
    smef_addr_t regAddr;
    smef_word_t regWdata, regRdata;
    smef_byte_t rxData, msgData, firstData;
    int fail_count, n_checks, nVal;
    smef_end_framer #(.MS_CYCLES(MS)) u_smef_end_framer (.sys_clk(sys_clk), .resetn(resetn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .rxValid(rxValid), .rxData(rxData), .rxBreak(rxBreak),
        .rxLineIdle(rxLineIdle), .txDone(txDone), .msgValid(msgValid), .msgData(msgData),
        .msgDone(msgDone), .msgError(msgError), .opBusy(opBusy));
    smef_remote_dev u_smef_remote_dev (.sys_clk(sys_clk), .rxValid(rxValid),
        .rxData(rxData), .rxBreak(rxBreak), .rxLineIdle(rxLineIdle));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Count delivered characters and keep the first
    always @(posedge sys_clk) begin
        if (msgValid === 1'b1) begin
            if (nVal == 0) firstData = msgData;
            nVal++;
        end
    end
    task chk(input smef_word_t got, input smef_word_t exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input smef_addr_t a, input smef_word_t d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rdchk(input smef_addr_t a, input smef_word_t exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(posedge sys_clk);
        chk(regRdata, exp);
    endtask : rdchk
    task go(input smef_word_t st, input smef_word_t en);
        wr(`SMEF_A_START, st);
        wr(`SMEF_A_END, en);
        nVal = 0;
        wr(`SMEF_A_CTRL, 32'h1);
    endtask : go
    // Bounded wait for the end, then status word and delivered count
    task await_end(input logic err, input logic [5:0] cause, input int cnt);
        for (int i = 0; i < 2000 && opBusy !== 1'b0; i++) @(posedge sys_clk);
        rdchk(`SMEF_A_CTRL, {16'(cnt), 2'h0, cause, 5'h0, err, ~err, 1'b0});
        chk(32'(nVal), 32'(cnt));
    endtask : await_end
    task lencase(input smef_word_t sz, input smef_byte_t s[$]);
        wr(`SMEF_A_LENSZ, sz);
        go(32'h02, 32'h10);
        u_smef_remote_dev.send_seq(s, 0);
        await_end(1'b0, 6'h10, s.size());
    endtask : lencase
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    // Watchdog well beyond the few hundred cycles the scenarios take
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        finish_test();
    end
    initial begin
        {resetn, regWrite, regRead, txDone, regAddr, regWdata} = '0;
        {fail_count, n_checks, nVal} = '0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rdchk(`SMEF_A_BAUD, 32'h364);
        rdchk(`SMEF_A_QUIET, 32'h0);
        rdchk(5'h1f, 32'h0);
        wr(`SMEF_A_MATCH, 32'h68);
        wr(`SMEF_A_MAXLEN, 32'h2);
        go(32'h01, 32'h08);
        u_smef_remote_dev.send_seq('{8'h55, 8'h68, 8'h01}, 1);
        await_end(1'b0, 6'h08, 2);
        chk(32'(firstData), 32'h68);
        wr(`SMEF_A_BAUD, 32'h4);
        wr(`SMEF_A_GAP, 32'h2);
        go(32'h02, 32'h04);
        u_smef_remote_dev.send_seq('{8'h11, 8'h22}, 2);
        await_end(1'b1, 6'h04, 2);
        wr(`SMEF_A_LENPOS, 32'h2);
        wr(`SMEF_A_LENM, 32'h1);
        lencase(32'h1, '{8'haa, 8'h02, 8'h01, 8'h02, 8'hcc});
        lencase(32'h2, '{8'haa, 8'h00, 8'h01, 8'h03, 8'hcc});
        lencase(32'h4, '{8'haa, 8'h00, 8'h00, 8'h00, 8'h01, 8'h07, 8'hcc});
        wr(`SMEF_A_SEQ + 5'h08, 32'h000a0d00);
        wr(`SMEF_A_SEQ + 5'h09, 32'h00000006);
        go(32'h02, 32'h20);
        u_smef_remote_dev.send_seq('{8'h41, 8'h0d, 8'h0a, 8'h01, 8'h02}, 0);
        await_end(1'b0, 6'h20, 5);
        wr(`SMEF_A_WAIT, 32'h2);
        wr(`SMEF_A_MAXLEN, 32'h4);
        go(32'h02, 32'h09);
        repeat (30) @(posedge sys_clk);
        txDone <= 1'b1;
        @(posedge sys_clk);
        txDone <= 1'b0;
        repeat (15) @(posedge sys_clk);
        rdchk(`SMEF_A_CTRL, 32'h1);
        await_end(1'b1, 6'h01, 0);
        wr(`SMEF_A_MSGT, 32'h2);
        wr(`SMEF_A_MAXLEN, 32'ha);
        go(32'h02, 32'h0a);
        u_smef_remote_dev.send_seq('{8'h01, 8'h02, 8'h03}, 1);
        await_end(1'b0, 6'h02, 3);
        wr(`SMEF_A_SEQ + 5'h02, 32'h68000068);
        wr(`SMEF_A_SEQ + 5'h03, 32'h9);
        wr(`SMEF_A_MAXLEN, 32'h2);
        go(32'h20, 32'h08);
        u_smef_remote_dev.send_seq('{8'h68, 8'h10, 8'haa, 8'h68, 8'hbb, 8'h10}, 0);
        await_end(1'b0, 6'h08, 2);
        chk(32'(firstData), 32'hbb);
        go(32'h21, 32'h08);
        u_smef_remote_dev.send_seq('{8'h10, 8'h68, 8'h10}, 0);
        await_end(1'b0, 6'h08, 2);
        chk(32'(firstData), 32'h68);
        wr(`SMEF_A_QUIET, 32'h3);
        go(32'h08, 32'h08);
        repeat (30) @(posedge sys_clk);
        u_smef_remote_dev.send_seq('{8'h31, 8'h32}, 0);
        await_end(1'b0, 6'h08, 2);
        go(32'h04, 32'h08);
        u_smef_remote_dev.send_break();
        u_smef_remote_dev.send_seq('{8'h44, 8'h45}, 0);
        await_end(1'b0, 6'h08, 2);
        go(32'h02, 32'h01);
        u_smef_remote_dev.send_seq('{8'h7e}, 0);
        repeat (60) @(posedge sys_clk);
        rdchk(`SMEF_A_CTRL, 32'h0001_0001);
        wr(`SMEF_A_CTRL, 32'h2);
        rdchk(`SMEF_A_CTRL, 32'h0001_0000);
        chk(32'(nVal), 32'h1);
        finish_test();
    end
endmodule : tb
`default_nettype wire
